// ===== rtl/psr_pkg.sv
// shared constants, types and tables of the parameter save/restore manager
package psr_pkg;

  // ---------------------------------------------------------------
  // command keywords and answers
  // ---------------------------------------------------------------
  localparam logic [31:0] STORE_KEY = 32'h65766173;
  localparam logic [31:0] RESTORE_KEY = 32'h64616F6C;
  localparam logic [31:0] REBOOT_KEY = 32'h746F6F62;
  localparam logic [31:0] DONE_VAL = 32'h00000001;
  localparam logic [31:0] DEFAULT_VAL = 32'h00000000;
  localparam logic [31:0] MARK_RST = 32'h00000000;

  // ---------------------------------------------------------------
  // store / restore subindices
  // ---------------------------------------------------------------
  localparam logic [7:0] SUB_ALL = 8'h01;
  localparam logic [7:0] SUB_COMM = 8'h02;
  localparam logic [7:0] SUB_APP = 8'h03;
  localparam logic [7:0] SUB_CUST = 8'h04;
  localparam logic [7:0] SUB_DRIVE = 8'h05;
  localparam logic [7:0] SUB_TUNE = 8'h06;
  localparam logic [7:0] SUB_ETH = 8'h0C;

  // ---------------------------------------------------------------
  // apb register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_MARK_DATE = 12'h000;
  localparam logic [11:0] ADDR_MARK_TIME = 12'h004;
  localparam logic [11:0] ADDR_REBOOT = 12'h008;
  localparam logic [11:0] ADDR_OBJ_SEL = 12'h00C;
  localparam logic [11:0] ADDR_OBJ_DATA = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [3:0] PAGE_STORE = 4'h1;
  localparam logic [3:0] PAGE_RESTORE = 4'h2;

  // ---------------------------------------------------------------
  // categories and masks (bit n of a mask selects category n)
  // ---------------------------------------------------------------
  localparam logic [2:0] CAT_NONE = 3'h0;
  localparam logic [2:0] CAT_COMM = 3'h1;
  localparam logic [2:0] CAT_APP = 3'h2;
  localparam logic [2:0] CAT_CUST = 3'h3;
  localparam logic [2:0] CAT_DRIVE = 3'h4;
  localparam logic [2:0] CAT_TUNE = 3'h5;
  localparam logic [2:0] CAT_ETH = 3'h6;
  localparam logic [2:0] CAT_MARK = 3'h7;
  localparam logic [7:0] MASK_SAVE_ALL = 8'hBE;
  localparam logic [7:0] MASK_REST_ALL = 8'h9E;
  localparam logic [7:0] MASK_LOAD = 8'hFE;

  // ---------------------------------------------------------------
  // object slots
  // ---------------------------------------------------------------
  localparam int MEM_DEPTH = 32;
  localparam int MEM_AW = 5;
  localparam int OBJ_NUM = 16;
  localparam logic [4:0] SLOT_DATE = 5'h1E;
  localparam logic [4:0] SLOT_TIME = 5'h1F;
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam logic [15:0] OBJ_IDX [OBJ_NUM] = '{
    16'h2102, 16'h3501, 16'h3601, 16'h2038, 16'h2800, 16'h6040, 16'h6060, 16'h2701,
    16'h3202, 16'h320D, 16'h6073, 16'h6080, 16'h2030, 16'h2031, 16'h6075, 16'h2011};
  localparam logic [2:0] OBJ_CAT [OBJ_NUM] = '{
    CAT_COMM, CAT_COMM, CAT_COMM, CAT_APP, CAT_APP, CAT_APP, CAT_APP, CAT_CUST,
    CAT_DRIVE, CAT_DRIVE, CAT_DRIVE, CAT_DRIVE, CAT_TUNE, CAT_TUNE, CAT_TUNE, CAT_ETH};

  typedef enum {ST_IDLE, ST_RD, ST_WR} psr_state_e;
  typedef enum logic [1:0] {OP_SAVE, OP_DISCARD, OP_LOAD} psr_op_e;

  function automatic logic [7:0] psr_cat_mask(input logic [7:0] sub, input logic rest);
    logic [7:0] m;
    m = 8'h00;
    case (sub)
      SUB_ALL: m = rest ? MASK_REST_ALL : MASK_SAVE_ALL;
      SUB_COMM: m = 8'h01 << CAT_COMM;
      SUB_APP: m = 8'h01 << CAT_APP;
      SUB_CUST: m = 8'h01 << CAT_CUST;
      SUB_DRIVE: m = 8'h01 << CAT_DRIVE;
      SUB_TUNE: m = 8'h01 << CAT_TUNE;
      SUB_ETH: m = 8'h01 << CAT_ETH;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

endpackage

// ===== rtl/psr_mem_if.sv
// port bundle of one slot memory
`timescale 1ns/1ps
interface psr_mem_if import psr_pkg::*; #(parameter int W = 32);
  logic we;
  logic [MEM_AW-1:0] waddr;
  logic [MEM_AW-1:0] raddr;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  modport owner(output we, waddr, raddr, wdata, input rdata);
  modport mem(input we, waddr, raddr, wdata, output rdata);
endinterface

// ===== rtl/psr_mem.sv
// slot memory with registered read data, no reset so contents persist
`timescale 1ns/1ps
module psr_mem import psr_pkg::*; #(parameter int W = 32) (
  // clock
  input wire logic clk,
  // access port
  psr_mem_if.mem port
);
  logic [W-1:0] cells [MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (port.we) begin
      cells[port.waddr] <= port.wdata;
    end
    port.rdata <= cells[port.raddr];
  end
endmodule // psr_mem

// ===== rtl/psr_obj_class.sv
// maps object indices to slots and slots to categories
`timescale 1ns/1ps
module psr_obj_class import psr_pkg::*; (
  // object lookup
  input wire logic [15:0] objIndex,
  output logic objHit,
  output logic [4:0] objSlot,
  // slot walk lookup
  input wire logic [4:0] walkSlot,
  output logic [2:0] walkCat
);
  logic [OBJ_NUM-1:0] match;

  genvar gi;
  generate
    for (gi = 0; gi < OBJ_NUM; gi++) begin : g_cmp
      assign match[gi] = (objIndex == OBJ_IDX[gi]);
    end
  endgenerate

  always_comb begin
    objHit = 1'b0;
    objSlot = 5'h00;
    for (int i = 0; i < OBJ_NUM; i++) begin
      if (match[i]) begin
        objHit = 1'b1;
        objSlot = 5'(i);
      end
    end
  end

  assign walkCat = (walkSlot == SLOT_DATE || walkSlot == SLOT_TIME) ? CAT_MARK :
                   (walkSlot < 5'(OBJ_NUM)) ? OBJ_CAT[walkSlot[3:0]] : CAT_NONE;
endmodule // psr_obj_class

// ===== rtl/psr_param_mgr.sv
// parameter save/restore manager with apb register access
//
// Contract
// - store keyword in a store subindex saves that category to non-volatile slots
// - store subindex reads one once the save has finished
// - store subindex 01 saves all but ethernet; others select one category
// - restore keyword discards saved objects of the selected category
// - restore subindex 01 spares tuning and ethernet; 06 and 0C reach them
// - discard leaves running values; defaults appear only after restart
// - reboot keyword in reboot entry restarts and reloads saved values
// - writes to savable objects clear markers, except marker and store 01
// - markers are saved with every category but ethernet by store subindex 01
// - communication category holds bus control and both mapping entries
// - drive category holds submode, inertia, max current, max speed
// - tuning category holds pole pairs, max motor current, rated current
// - only whole categories are saved; uncategorised objects never are
// - saved values reload at every reset and live outside reset
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module psr_param_mgr import psr_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system side
  output logic saveBusy,
  output logic restartPulse
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  psr_state_e state_r;
  psr_op_e op_r;
  logic [7:0] mask_r;
  logic [7:0] curSub_r;
  logic [4:0] slot_r;
  logic [31:0] markDate_r;
  logic [31:0] markTime_r;
  logic [15:0] objSel_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic busyOut_r;
  logic restart_r;

  psr_mem_if #(.W(32)) runIf();
  psr_mem_if #(.W(33)) nvIf();

  logic objHit;
  logic [4:0] objSlot;
  logic [2:0] walkCat;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire busy = (state_r != ST_IDLE);
  wire capture = psel & penable & ~pready_r;
  wire wrDone = psel & penable & pready_r & pwrite;
  wire inStore = (paddr[11:8] == PAGE_STORE) && (paddr[1:0] == 2'b00);
  wire inRest = (paddr[11:8] == PAGE_RESTORE) && (paddr[1:0] == 2'b00);
  wire [7:0] sub = {2'b00, paddr[7:2]};
  wire [7:0] subMask = psr_cat_mask(sub, inRest);
  wire subOk = (subMask != 8'h00);
  wire hitDate = (paddr == ADDR_MARK_DATE);
  wire hitTime = (paddr == ADDR_MARK_TIME);
  wire hitReboot = (paddr == ADDR_REBOOT);
  wire hitSel = (paddr == ADDR_OBJ_SEL);
  wire hitData = (paddr == ADDR_OBJ_DATA);
  wire hitStat = (paddr == ADDR_STATUS);
  wire mapped = ((inStore | inRest) & subOk) | hitDate | hitTime | hitReboot
                | hitSel | hitData | hitStat;
  // the walk owns both memory ports, so object access during it is rejected with pslverr
  wire bad = ~mapped | (pwrite & busy & ~hitStat) | (hitData & (busy | ~objHit));
  wire wrOk = wrDone & ~pslverr_r;

  // ---------------------------------------------------------------
  // commands
  // ---------------------------------------------------------------
  // only the exact keyword starts a save
  wire saveGo = wrOk & inStore & (pwdata == STORE_KEY);
  // only the exact keyword starts a discard
  wire discGo = wrOk & inRest & (pwdata == RESTORE_KEY);
  wire bootGo = wrOk & hitReboot & (pwdata == REBOOT_KEY);
  wire objWe = wrOk & hitData;
  // savable writes clear the markers; store 01 and markers do not
  wire markClr = wrOk & ((inStore & (sub != SUB_ALL)) | hitReboot | objWe);

  // ---------------------------------------------------------------
  // slot walk datapath
  // ---------------------------------------------------------------
  wire walkWr = (state_r == ST_WR);
  // only slots of the chosen categories move
  wire slotSel = mask_r[walkCat];
  // marker slots take their words from the marker registers
  wire [31:0] srcWord = (slot_r == SLOT_DATE) ? markDate_r :
                        (slot_r == SLOT_TIME) ? markTime_r : runIf.rdata;
  // saved word if valid, default otherwise
  wire [31:0] loadWord = nvIf.rdata[32] ? nvIf.rdata[31:0] : DEFAULT_VAL;
  wire loadWr = walkWr & (op_r == OP_LOAD) & slotSel;
  wire nvWe = walkWr & (op_r != OP_LOAD) & slotSel;
  // discard clears the whole saved copy, valid bit and word
  wire [32:0] nvWdata = (op_r == OP_SAVE) ? {1'b1, srcWord} : 33'h000000000;
  wire runLoadWe = loadWr & (walkCat != CAT_MARK);

  assign nvIf.we = nvWe;
  assign nvIf.waddr = slot_r;
  assign nvIf.raddr = slot_r;
  assign nvIf.wdata = nvWdata;
  assign runIf.we = objWe | runLoadWe;
  assign runIf.waddr = busy ? slot_r : objSlot;
  assign runIf.raddr = busy ? slot_r : objSlot;
  assign runIf.wdata = busy ? loadWord : pwdata;

  psr_mem #(.W(32)) uRunMem (
    .clk(ref_clk),
    .port(runIf.mem)
  );

  psr_mem #(.W(33)) uNvMem (
    .clk(ref_clk),
    .port(nvIf.mem)
  );

  psr_obj_class uClass (
    .objIndex(objSel_r),
    .objHit(objHit),
    .objSlot(objSlot),
    .walkSlot(slot_r),
    .walkCat(walkCat)
  );

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // keyword while its own save or discard runs, one otherwise
  wire storeRun = busy & (op_r == OP_SAVE) & (curSub_r == sub);
  wire restRun = busy & (op_r == OP_DISCARD) & (curSub_r == sub);
  wire [31:0] statWord = {16'h0000, curSub_r, 5'h00, op_r, busy};
  wire [31:0] rdMux = bad ? 32'h00000000 :
                      inStore ? (storeRun ? STORE_KEY : DONE_VAL) :
                      inRest ? (restRun ? RESTORE_KEY : DONE_VAL) :
                      hitDate ? markDate_r :
                      hitTime ? markTime_r :
                      hitSel ? {16'h0000, objSel_r} :
                      hitData ? runIf.rdata :
                      hitStat ? statWord : 32'h00000000;

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // one wait state lets the memory read follow a write just before
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= capture;
      if (capture) begin
        pslverr_r <= bad;
        prdata_r <= pwrite ? 32'h00000000 : rdMux;
      end else if (pready_r) begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // walk sequencer
  // ---------------------------------------------------------------
  // reset starts a reload walk
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_RD;
      op_r <= OP_LOAD;
      mask_r <= MASK_LOAD;
      curSub_r <= 8'h00;
      slot_r <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          slot_r <= 5'h00;
          if (saveGo | discGo) begin
            state_r <= ST_RD;
            op_r <= saveGo ? OP_SAVE : OP_DISCARD;
            mask_r <= subMask;
            curSub_r <= sub;
          end else if (bootGo) begin
            state_r <= ST_RD;
            op_r <= OP_LOAD;
            mask_r <= MASK_LOAD;
            curSub_r <= 8'h00;
          end
        end
        ST_RD: begin
          state_r <= ST_WR;
        end
        ST_WR: begin
          slot_r <= slot_r + 5'h01;
          state_r <= (slot_r == SLOT_LAST) ? ST_IDLE : ST_RD;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // markers, object select and system outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      markDate_r <= MARK_RST;
      markTime_r <= MARK_RST;
      objSel_r <= 16'h0000;
      busyOut_r <= 1'b1;
      restart_r <= 1'b0;
    end else begin
      busyOut_r <= busy;
      restart_r <= bootGo;
      if (wrOk & hitSel) begin
        objSel_r <= pwdata[15:0];
      end
      if (markClr) begin
        markDate_r <= MARK_RST;
        markTime_r <= MARK_RST;
      end else if (loadWr & (slot_r == SLOT_DATE)) begin
        markDate_r <= loadWord;
      end else if (loadWr & (slot_r == SLOT_TIME)) begin
        markTime_r <= loadWord;
      end else begin
        if (wrOk & hitDate) begin
          markDate_r <= pwdata;
        end
        if (wrOk & hitTime) begin
          markTime_r <= pwdata;
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign saveBusy = busyOut_r;
  assign restartPulse = restart_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_save_start: assert property (
    saveGo && !busy |=> state_r == ST_RD && op_r == OP_SAVE && curSub_r == $past(sub))
    else $error("save keyword did not start a save");

  chk_save_finish: assert property (
    saveGo && !busy |=> busy [*8] ##57 state_r == ST_IDLE)
    else $error("save did not finish in 64 cycles");

  chk_all_no_eth: assert property (
    walkWr && op_r == OP_SAVE && curSub_r == SUB_ALL && walkCat == CAT_ETH |-> !nvIf.we)
    else $error("save-all touched ethernet");

  chk_tune_kept: assert property (
    walkWr && op_r == OP_DISCARD && curSub_r == SUB_ALL && walkCat == CAT_TUNE |-> !nvIf.we)
    else $error("factory reset touched tuning");

  chk_discard_run: assert property (
    busy && op_r == OP_DISCARD |-> !runIf.we)
    else $error("discard changed a running value");

  chk_reboot_load: assert property (
    bootGo |=> op_r == OP_LOAD && state_r == ST_RD && restartPulse)
    else $error("reboot keyword did not restart");

  chk_marker_clear: assert property (
    markClr |=> markDate_r == MARK_RST && markTime_r == MARK_RST)
    else $error("marker not cleared");

  chk_marker_saved: assert property (
    nvIf.we && op_r == OP_SAVE && slot_r == SLOT_TIME |-> nvIf.wdata == {1'b1, markTime_r})
    else $error("marker time not saved");

  chk_bad_key: assert property (
    wrOk && inStore && pwdata != STORE_KEY && !busy |=> state_r == ST_IDLE)
    else $error("wrong keyword started a save");

  chk_key_reads: assert property (
    capture && !pwrite && inStore && storeRun |=> pready && prdata == STORE_KEY)
    else $error("running save read back as done");

  cov_save_all: cover property (saveGo && sub == SUB_ALL);
  cov_discard: cover property (discGo ##[1:80] state_r == ST_IDLE);
  cov_reboot: cover property (bootGo);
endmodule // psr_param_mgr

// ===== sim/psr_apb_master.sv
// apb master model standing in for the configuration tool
`timescale 1ns/1ps
module psr_apb_master import psr_pkg::*; (
  // clock
  input wire logic ref_clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // device status
  input wire logic saveBusy
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // ----------------------------------------
  // bus cycle
  // ----------------------------------------
  // request held until pready is seen; only the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    rd = 32'hX;
    err = 1'hX;
    @(posedge ref_clk);
    while (pready !== 1'h1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // released data must not keep showing the last word
    pwdata <= ~d;
  endtask

  // ----------------------------------------
  // commands
  // ----------------------------------------
  // wait for completion, seen as saveBusy low
  task automatic waitIdle();
    repeat (4) @(posedge ref_clk);
    while (saveBusy !== 1'h0) begin
      @(posedge ref_clk);
    end
  endtask

  // keyword into store, restore or reboot entry
  task automatic command(input logic [11:0] a, input logic [31:0] key, output logic err);
    logic [31:0] rd;
    xfer(1'h1, a, key, rd, err);
    waitIdle();
  endtask
endmodule // psr_apb_master

// ===== sim/tb_top.sv
// self-checking bench of the parameter save/restore manager
`timescale 1ns/1ps
module tb_top import psr_pkg::*;;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic ref_clk;
  logic resetn;
  logic psel, penable, pwrite, pready, pslverr, saveBusy, restartPulse, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, dateV, timeV, valA;
  logic [31:0] tv [10];
  int err_total;
  int n_checks;
  int pulses;
  localparam logic [15:0] TIDX [10] = '{16'h2102, 16'h3501, 16'h3601, 16'h3202, 16'h6073,
    16'h6080, 16'h2030, 16'h2031, 16'h6075, 16'h2011};
  localparam logic [7:0] SUBS [7] = '{SUB_ALL, SUB_COMM, SUB_APP, SUB_CUST, SUB_DRIVE,
    SUB_TUNE, SUB_ETH};
  localparam logic [7:0] CATS [4] = '{SUB_COMM, SUB_DRIVE, SUB_TUNE, SUB_ETH};

  psr_param_mgr dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .saveBusy(saveBusy), .restartPulse(restartPulse));
  psr_apb_master mst (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .saveBusy(saveBusy));

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // counting high cycles proves a single-cycle pulse
  always @(posedge ref_clk) begin
    if (restartPulse === 1'h1) begin
      pulses++;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [11:0] storeAddr(input logic [7:0] s);
    return 12'h100 + {2'h0, s, 2'h0};
  endfunction
  function automatic logic [11:0] restAddr(input logic [7:0] s);
    return 12'h200 + {2'h0, s, 2'h0};
  endfunction
  function automatic logic [31:0] busyStat(input logic [7:0] s, input logic [1:0] op);
    return {16'h0, s, 5'h0, op, 1'h1};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    mst.xfer(1'h1, a, d, rd, err);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    mst.xfer(1'h0, a, 32'h0, rd, err);
    check(rd, exp);
  endtask
  task automatic setObj(input logic [15:0] idx, input logic [31:0] v);
    wr(ADDR_OBJ_SEL, {16'h0, idx});
    wr(ADDR_OBJ_DATA, v);
  endtask
  task automatic objChk(input logic [15:0] idx, input logic [31:0] exp);
    wr(ADDR_OBJ_SEL, {16'h0, idx});
    rdChk(ADDR_OBJ_DATA, exp);
  endtask
  task automatic idleChk();
    mst.xfer(1'h0, ADDR_STATUS, 32'h0, rd, err);
    check({31'h0, rd[0]}, 32'h0);
  endtask
  task automatic reboot();
    int p;
    p = pulses;
    wr(ADDR_REBOOT, REBOOT_KEY);
    mst.waitIdle();
    check(32'(pulses - p), 32'h1);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #100000;
    err_total++;
    results();
  end

  initial begin
    resetn = 1'h0;
    err_total = 0;
    n_checks = 0;
    pulses = 0;
    void'($urandom(3));
    dateV = $urandom() | 32'h1;
    timeV = $urandom() | 32'h1;
    valA = $urandom() | 32'h1;
    foreach (tv[i]) tv[i] = $urandom() | 32'h1;
    repeat (6) @(posedge ref_clk);
    check({31'h0, saveBusy}, 32'h1);
    resetn <= 1'h1;
    wr(ADDR_MARK_DATE, dateV);
    check({31'h0, err}, 32'h1);
    mst.waitIdle();
    mst.xfer(1'h1, 12'h11C, STORE_KEY, rd, err);
    check({31'h0, err}, 32'h1);
    foreach (SUBS[i]) rdChk(storeAddr(SUBS[i]), DONE_VAL);
    // wrong keywords: bit 31 set never matches a keyword
    wr(ADDR_MARK_DATE, dateV);
    wr(ADDR_MARK_TIME, timeV);
    wr(storeAddr(SUB_ALL), $urandom() | 32'h80000000);
    idleChk();
    rdChk(ADDR_MARK_DATE, dateV);
    wr(restAddr(SUB_COMM), $urandom() | 32'h80000000);
    idleChk();
    wr(storeAddr(SUB_TUNE), $urandom() | 32'h80000000);
    idleChk();
    rdChk(ADDR_MARK_DATE, MARK_RST);
    rdChk(ADDR_MARK_TIME, MARK_RST);
    foreach (SUBS[i]) begin
      wr(storeAddr(SUBS[i]), STORE_KEY);
      rdChk(storeAddr(SUBS[i]), STORE_KEY);
      rdChk(ADDR_STATUS, busyStat(SUBS[i], 2'h0));
      wr(ADDR_MARK_DATE, dateV);
      check({31'h0, err}, 32'h1);
      mst.waitIdle();
      rdChk(storeAddr(SUBS[i]), DONE_VAL);
    end
    // category membership by single-category saves
    foreach (TIDX[i]) setObj(TIDX[i], tv[i]);
    foreach (CATS[i]) mst.command(storeAddr(CATS[i]), STORE_KEY, err);
    reboot();
    foreach (TIDX[i]) objChk(TIDX[i], tv[i]);
    setObj(16'h2011, ~tv[9]);
    setObj(16'h6060, valA);
    rdChk(ADDR_MARK_DATE, MARK_RST);
    wr(ADDR_MARK_DATE, dateV);
    wr(ADDR_MARK_TIME, timeV);
    mst.command(storeAddr(SUB_ALL), STORE_KEY, err);
    rdChk(ADDR_MARK_TIME, timeV);
    reboot();
    rdChk(ADDR_MARK_DATE, dateV);
    rdChk(ADDR_MARK_TIME, timeV);
    objChk(16'h6060, valA);
    objChk(16'h2011, tv[9]);
    // single-category discard hits drive only
    mst.command(restAddr(SUB_DRIVE), RESTORE_KEY, err);
    reboot();
    objChk(16'h3202, 32'h0);
    objChk(16'h2102, tv[0]);
    wr(restAddr(SUB_ALL), RESTORE_KEY);
    rdChk(ADDR_STATUS, busyStat(SUB_ALL, 2'h1));
    mst.waitIdle();
    objChk(16'h6060, valA);
    reboot();
    objChk(16'h6060, 32'h0);
    objChk(16'h2031, tv[7]);
    objChk(16'h2011, tv[9]);
    mst.command(restAddr(SUB_TUNE), RESTORE_KEY, err);
    mst.command(restAddr(SUB_ETH), RESTORE_KEY, err);
    reboot();
    objChk(16'h2031, 32'h0);
    objChk(16'h2011, 32'h0);
    // reset while idle, after an object write, must reload the saved copies
    setObj(16'h6060, valA);
    resetn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'h1;
    mst.waitIdle();
    objChk(16'h6060, 32'h0);
    results();
  end
endmodule // tb_top
